// ### gpio_pkg.sv
package gpio_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] PORT_A_DIRECTION = 8'hF0;
  localparam logic [7:0] PORT_A_DATA = 8'hF1;
  localparam logic [7:0] PORT_B_DATA = 8'hF2;
  localparam logic [7:0] PORT_C_DIRECTION = 8'hF3;
  localparam logic [7:0] PORT_C_DATA = 8'hF4;
  localparam logic [7:0] PORT_D_DIRECTION = 8'hF5;
  localparam logic [7:0] PORT_D_DATA = 8'hF6;

  // ---------------------------------------------------------------
  // Reset values and field layout
  // ---------------------------------------------------------------
  localparam logic [7:0] DIRECTION_RESET = 8'hFF;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] ALL_PINS = 8'hFF;
  localparam logic [7:0] NO_PINS = 8'h00;
  localparam int PORT_B_BIT4 = 4;
  localparam logic [7:0] PORT_C_USED = 8'h9F;
  localparam logic [7:0] PORT_D_NARROW = 8'h33;
  localparam int PWM_BIT = 7;
  localparam int FLASH_WIDTH = 5;
  localparam int PANEL_WIDTH_BITS = 24;
  // Panel data line behind each port D bit, bit 0 first
  localparam int PANEL_MAP [8] = '{0, 1, 8, 9, 16, 17, 2, 18};

  // ---------------------------------------------------------------
  // Mode encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] HOST_PARALLEL16 = 2'h0;
  localparam logic [1:0] HOST_PARALLEL8 = 2'h1;
  localparam logic [1:0] HOST_SERIAL = 2'h2;
  localparam logic [1:0] PANEL_BUS24 = 2'h0;
  localparam logic [1:0] PANEL_BUS18 = 2'h1;
  localparam logic [1:0] PANEL_BUS16 = 2'h2;
  localparam logic [1:0] PANEL_BUS12 = 2'h3;

  typedef enum logic [1:0] {
    HOST_WIDE,
    HOST_NARROW,
    HOST_SERIAL_LINK
  } hostKind_type;

endpackage

// ### pad_if.sv
`timescale 1ns/1ps
interface pad_if;
  logic [7:0] gpioData;
  logic [7:0] gpioDir;
  logic [7:0] altOwn;
  logic [7:0] altOut;
  logic [7:0] altOe;
  logic [7:0] pinOut;
  logic [7:0] pinOe;

  modport ctrl (
    output gpioData,
    output gpioDir,
    output altOwn,
    output altOut,
    output altOe,
    input pinOut,
    input pinOe
  );

  modport mux (
    input gpioData,
    input gpioDir,
    input altOwn,
    input altOut,
    input altOe,
    output pinOut,
    output pinOe
  );
endinterface

// ### pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // ---------------------------------------------------------------
  // Two stage synchroniser, first stage feeds only the second
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] stage_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      stage_reg <= '0;
      q <= '0;
    end else begin
      stage_reg <= d;
      q <= stage_reg;
    end
  end

endmodule

// ### pad_mux.sv
`timescale 1ns/1ps
module pad_mux (
  pad_if.mux pads
);

  // ---------------------------------------------------------------
  // Per pin ownership: alternate function wins outright
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      // Owned pins ignore gpio data and direction entirely
      assign pads.pinOut[i] = pads.altOwn[i] ? pads.altOut[i] : pads.gpioData[i];
      assign pads.pinOe[i] = pads.altOwn[i] ? pads.altOe[i] : ~pads.gpioDir[i];
    end
  endgenerate

endmodule

// ### shared_pin_gpio_ports.sv
// Added by the designer: strobed register access.
`timescale 1ns/1ps
// Summary of operation
// - Ports A, C and D have 8-bit direction registers, 0 output and 1 input, all ones after reset.
// - Writing port A data drives the byte onto port A pins and reading returns the sampled pin levels.
// - Port A pins belong to the upper host data lines only while the host runs 16-bit parallel.
// - Port B bit 4 writes the keypad scan out 0 pin while keypad scanning is disabled and reads the keypad scan in 0 pin.
// - Port C bit 7 is a gpio only while both PWM and SPI master are disabled.
// - Port C bits 4 to 0 share the flash lines and are gpio only while PWM and SPI master are disabled.
// - Port C and D data drive output pins; reads return the pin levels, except port C bits 6 and 5, which read zero.
// - Port D bits 7 to 0 map to panel data lines 18, 2, 17, 16, 9, 8, 1 and 0.
// - Port D bits 5, 4, 1 and 0 are gpio only with a 16 or 12 bit panel bus.
// - Port D bits 7, 6, 3 and 2 are gpio only with a 16 bit panel bus.
module shared_pin_gpio_ports (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regReadData,
  input wire logic [1:0] hostMode,
  input wire logic [7:0] hostDataOut,
  input wire logic [7:0] hostDataOe,
  input wire logic [7:0] portAIn,
  output logic [7:0] portAOut,
  output logic [7:0] portAOe,
  input wire logic keypadScanEnable,
  input wire logic keypadScanOut0,
  output logic portBBit4Output,
  input wire logic portBBit4Input,
  input wire logic [3:0] portBLowInputs,
  input wire logic pwmEnable,
  input wire logic spiMasterEnable,
  input wire logic pwmOut0,
  input wire logic [4:0] flashOut,
  input wire logic [4:0] flashOe,
  input wire logic [7:0] portCIn,
  output logic [7:0] portCOut,
  output logic [7:0] portCOe,
  input wire logic [1:0] panelWidth,
  input wire logic [23:0] panelData,
  input wire logic [7:0] portDIn,
  output logic [7:0] portDOut,
  output logic [7:0] portDOe
);

  // ---------------------------------------------------------------
  // Decode helper
  // ---------------------------------------------------------------
  function automatic logic hit(input logic strobe, input logic [7:0] addr, input logic [7:0] offset);
    hit = strobe && (addr == offset);
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] portADirection_reg;
  logic [7:0] portAData_reg;
  logic portBBit4_reg;
  logic [7:0] portCDirection_reg;
  logic [7:0] portCData_reg;
  logic [7:0] portDDirection_reg;
  logic [7:0] portDData_reg;
  logic [7:0] readData_reg;
  logic [7:0] readData_next;

  // ---------------------------------------------------------------
  // Synchronised pin levels
  // ---------------------------------------------------------------
  logic [7:0] portASync;
  logic [7:0] portCSync;
  logic [7:0] portDSync;
  logic [4:0] portBSync;

  pin_sync #(.WIDTH(8)) syncA (
    .clk(clk),
    .reset(reset),
    .d(portAIn),
    .q(portASync)
  );

  pin_sync #(.WIDTH(8)) syncC (
    .clk(clk),
    .reset(reset),
    .d(portCIn),
    .q(portCSync)
  );

  pin_sync #(.WIDTH(8)) syncD (
    .clk(clk),
    .reset(reset),
    .d(portDIn),
    .q(portDSync)
  );

  pin_sync #(.WIDTH(5)) syncB (
    .clk(clk),
    .reset(reset),
    .d({portBBit4Input, portBLowInputs}),
    .q(portBSync)
  );

  // ---------------------------------------------------------------
  // Ownership of shared pins
  // ---------------------------------------------------------------
  logic hostSerial;
  logic portCAltActive;
  logic [7:0] portAOwn;
  logic [7:0] portCOwn;
  logic [7:0] portDOwn;
  logic [7:0] portDFree;
  logic [7:0] panelPick;

  assign hostSerial = (hostMode == gpio_pkg::HOST_SERIAL);
  // Only full 16-bit host mode claims the upper data lines
  assign portAOwn = (hostMode == gpio_pkg::HOST_PARALLEL16) ? gpio_pkg::ALL_PINS : gpio_pkg::NO_PINS;
  assign portCAltActive = pwmEnable || spiMasterEnable;
  assign portCOwn = portCAltActive ? gpio_pkg::PORT_C_USED : gpio_pkg::NO_PINS;

  always_comb begin
    case (panelWidth)
      gpio_pkg::PANEL_BUS16: portDFree = gpio_pkg::ALL_PINS;
      gpio_pkg::PANEL_BUS12: portDFree = gpio_pkg::PORT_D_NARROW;
      default: portDFree = gpio_pkg::NO_PINS;
    endcase
  end

  assign portDOwn = ~portDFree;

  genvar k;
  generate
    for (k = 0; k < 8; k++) begin : g_panel
      assign panelPick[k] = panelData[gpio_pkg::PANEL_MAP[k]];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Pad multiplexers
  // ---------------------------------------------------------------
  pad_if padsA ();
  pad_if padsC ();
  pad_if padsD ();

  assign padsA.gpioData = portAData_reg;
  assign padsA.gpioDir = portADirection_reg;
  assign padsA.altOwn = portAOwn;
  assign padsA.altOut = hostDataOut;
  assign padsA.altOe = hostDataOe;
  assign portAOut = padsA.pinOut;
  assign portAOe = padsA.pinOe;

  // Bits 6 and 5 have no pin behind them, so they are held as inputs
  assign padsC.gpioData = portCData_reg;
  assign padsC.gpioDir = portCDirection_reg | ~gpio_pkg::PORT_C_USED;
  assign padsC.altOwn = portCOwn;
  assign padsC.altOut = {pwmOut0, 2'h0, flashOut};
  assign padsC.altOe = {1'b1, 2'h0, flashOe};
  assign portCOut = padsC.pinOut;
  assign portCOe = padsC.pinOe;

  // The panel drives its lines whenever it owns them
  assign padsD.gpioData = portDData_reg;
  assign padsD.gpioDir = portDDirection_reg;
  assign padsD.altOwn = portDOwn;
  assign padsD.altOut = panelPick;
  assign padsD.altOe = gpio_pkg::ALL_PINS;
  assign portDOut = padsD.pinOut;
  assign portDOe = padsD.pinOe;

  pad_mux muxA (
    .pads(padsA)
  );

  pad_mux muxC (
    .pads(padsC)
  );

  pad_mux muxD (
    .pads(padsD)
  );

  // Keypad scanning owns the dedicated output while enabled
  assign portBBit4Output = keypadScanEnable ? keypadScanOut0 : portBBit4_reg;

  // ---------------------------------------------------------------
  // Direction registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      portADirection_reg <= gpio_pkg::DIRECTION_RESET;
      portCDirection_reg <= gpio_pkg::DIRECTION_RESET;
      portDDirection_reg <= gpio_pkg::DIRECTION_RESET;
    end else begin
      if (hit(regWrite, regAddr, gpio_pkg::PORT_A_DIRECTION)) begin
        portADirection_reg <= regWriteData;
      end
      if (hit(regWrite, regAddr, gpio_pkg::PORT_C_DIRECTION)) begin
        portCDirection_reg <= regWriteData;
      end
      if (hit(regWrite, regAddr, gpio_pkg::PORT_D_DIRECTION)) begin
        portDDirection_reg <= regWriteData;
      end
    end
  end

  // ---------------------------------------------------------------
  // Data registers
  // ---------------------------------------------------------------
  // Writes always land in storage; ownership is applied only at the pad,
  // so a value written while owned appears once the function releases
  always_ff @(posedge clk) begin
    if (reset) begin
      portAData_reg <= gpio_pkg::DATA_RESET;
      portBBit4_reg <= 1'b0;
      portCData_reg <= gpio_pkg::DATA_RESET;
      portDData_reg <= gpio_pkg::DATA_RESET;
    end else begin
      if (hit(regWrite, regAddr, gpio_pkg::PORT_A_DATA)) begin
        portAData_reg <= regWriteData;
      end
      if (hit(regWrite, regAddr, gpio_pkg::PORT_B_DATA)) begin
        portBBit4_reg <= regWriteData[gpio_pkg::PORT_B_BIT4];
      end
      if (hit(regWrite, regAddr, gpio_pkg::PORT_C_DATA)) begin
        portCData_reg <= regWriteData;
      end
      if (hit(regWrite, regAddr, gpio_pkg::PORT_D_DATA)) begin
        portDData_reg <= regWriteData;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb begin
    readData_next = 8'h00;
    case (regAddr)
      gpio_pkg::PORT_A_DIRECTION: readData_next = portADirection_reg;
      gpio_pkg::PORT_A_DATA: readData_next = portASync;
      gpio_pkg::PORT_B_DATA: begin
        readData_next[gpio_pkg::PORT_B_BIT4] = portBSync[4];
        // Low inputs only carry meaning with the serial host
        readData_next[3:0] = hostSerial ? portBSync[3:0] : 4'h0;
      end
      gpio_pkg::PORT_C_DIRECTION: readData_next = portCDirection_reg;
      gpio_pkg::PORT_C_DATA: readData_next = portCSync & gpio_pkg::PORT_C_USED;
      gpio_pkg::PORT_D_DIRECTION: readData_next = portDDirection_reg;
      gpio_pkg::PORT_D_DATA: readData_next = portDSync;
      default: readData_next = 8'h00;
    endcase
  end

  // Read data stand for exactly the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      readData_reg <= 8'h00;
    end else if (regRead) begin
      readData_reg <= readData_next;
    end else begin
      readData_reg <= 8'h00;
    end
  end

  assign regReadData = readData_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  dir_reset_value_a: assert property (
    @(posedge clk) disable iff (1'b0)
    reset |=> (portADirection_reg == gpio_pkg::DIRECTION_RESET)
      && (portCDirection_reg == gpio_pkg::DIRECTION_RESET)
      && (portDDirection_reg == gpio_pkg::DIRECTION_RESET)
  ) else $error("direction not all ones after reset");

  dir_output_enable_a: assert property (
    hit(regWrite, regAddr, gpio_pkg::PORT_A_DIRECTION) && (hostMode != gpio_pkg::HOST_PARALLEL16)
      ##1 (hostMode != gpio_pkg::HOST_PARALLEL16) |-> portAOe == ~$past(regWriteData)
  ) else $error("port A enable does not follow direction");

  port_a_drive_a: assert property (
    hit(regWrite, regAddr, gpio_pkg::PORT_A_DATA) ##1 (hostMode != gpio_pkg::HOST_PARALLEL16)
      |-> portAOut == $past(regWriteData)
  ) else $error("port A pins do not show written byte");

  port_a_read_a: assert property (
    hit(regRead, regAddr, gpio_pkg::PORT_A_DATA) |=> regReadData == $past(portAIn, 3)
  ) else $error("port A read is not the sampled pin level");

  host_owns_a: assert property (
    (hostMode == gpio_pkg::HOST_PARALLEL16) |-> (portAOut == hostDataOut) && (portAOe == hostDataOe)
  ) else $error("port A not handed to host data lines");

  keypad_bit_a: assert property (
    hit(regWrite, regAddr, gpio_pkg::PORT_B_DATA) ##1 !keypadScanEnable
      |-> portBBit4Output == $past(regWriteData[gpio_pkg::PORT_B_BIT4])
  ) else $error("port B bit 4 output wrong");

  serial_low_read_a: assert property (
    hit(regRead, regAddr, gpio_pkg::PORT_B_DATA) && !hostSerial |=> regReadData[3:0] == 4'h0
  ) else $error("port B low bits read outside serial mode");

  pwm_owns_a: assert property (
    portCAltActive |-> (portCOut[gpio_pkg::PWM_BIT] == pwmOut0) && portCOe[gpio_pkg::PWM_BIT]
  ) else $error("port C bit 7 not given to PWM");

  flash_owns_a: assert property (
    portCAltActive |-> (portCOut[4:0] == flashOut) && (portCOe[4:0] == flashOe)
  ) else $error("port C flash lines not given away");

  port_c_drive_a: assert property (
    hit(regWrite, regAddr, gpio_pkg::PORT_C_DATA) ##1 !portCAltActive
      |-> portCOut[4:0] == $past(regWriteData[4:0])
  ) else $error("port C pins do not show written data");

  panel_map_a: assert property (
    (panelWidth == gpio_pkg::PANEL_BUS24) |-> portDOut == {panelData[18], panelData[2], panelData[17],
      panelData[16], panelData[9], panelData[8], panelData[1], panelData[0]}
  ) else $error("panel line mapping wrong");

  narrow_panel_a: assert property (
    (panelWidth == gpio_pkg::PANEL_BUS12)
      |-> (portDOut[7] == panelData[18]) && (portDOe[5] == ~portDDirection_reg[5])
  ) else $error("12 bit panel ownership wrong");

  owned_write_a: assert property (
    hit(regWrite, regAddr, gpio_pkg::PORT_D_DATA) && (panelWidth == gpio_pkg::PANEL_BUS18)
      ##1 (panelWidth == gpio_pkg::PANEL_BUS18) |-> (portDOut == panelPick) && (portDOe == gpio_pkg::ALL_PINS)
  ) else $error("write disturbed an owned pin");

  port_a_write_c: cover property (
    hit(regWrite, regAddr, gpio_pkg::PORT_A_DIRECTION) ##[1:8] hit(regWrite, regAddr, gpio_pkg::PORT_A_DATA)
      ##[1:8] hit(regRead, regAddr, gpio_pkg::PORT_A_DATA)
  );
  serial_read_c: cover property (hostSerial && hit(regRead, regAddr, gpio_pkg::PORT_B_DATA));
  pwm_release_c: cover property (portCAltActive ##1 !portCAltActive);
  panel_narrow_c: cover property ((panelWidth == gpio_pkg::PANEL_BUS12) && hit(regWrite, regAddr, gpio_pkg::PORT_D_DIRECTION));

endmodule

// ### pin_world.sv
`timescale 1ns/1ps
module pin_world (
  input wire logic [7:0] aOut,
  input wire logic [7:0] aOe,
  input wire logic [7:0] cOut,
  input wire logic [7:0] cOe,
  input wire logic [7:0] dOut,
  input wire logic [7:0] dOe,
  input wire logic [7:0] extA,
  input wire logic [7:0] extC,
  input wire logic [7:0] extD,
  output logic [7:0] aIn,
  output logic [7:0] cIn,
  output logic [7:0] dIn
);
  // ---------------------------------------------------------------
  // Pin resolution
  // ---------------------------------------------------------------
  // Outside parts hold every released pin, so a read never sees a float
  assign aIn = (aOut & aOe) | (extA & ~aOe);
  assign cIn = (cOut & cOe) | (extC & ~cOe);
  assign dIn = (dOut & dOe) | (extD & ~dOe);
endmodule

// ### shared_pin_gpio_ports_bench.sv
`timescale 1ns/1ps
module shared_pin_gpio_ports_bench;
  logic clk, reset, regWrite, regRead, keypadScanEnable, keypadScanOut0, portBBit4Output, portBBit4Input;
  logic pwmEnable, spiMasterEnable, pwmOut0;
  logic [1:0] hostMode, panelWidth;
  logic [3:0] portBLowInputs;
  logic [4:0] flashOut, flashOe;
  logic [7:0] regAddr, regWriteData, regReadData, hostDataOut, hostDataOe, own;
  logic [7:0] portAIn, portAOut, portAOe, portCIn, portCOut, portCOe, portDIn, portDOut, portDOe;
  logic [23:0] panelData;
  int errors = 0;
  int samples_checked = 0;

  shared_pin_gpio_ports dut_u (.clk(clk), .reset(reset), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData), .hostMode(hostMode),
    .hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .portAIn(portAIn), .portAOut(portAOut),
    .portAOe(portAOe), .keypadScanEnable(keypadScanEnable), .keypadScanOut0(keypadScanOut0),
    .portBBit4Output(portBBit4Output), .portBBit4Input(portBBit4Input), .portBLowInputs(portBLowInputs),
    .pwmEnable(pwmEnable), .spiMasterEnable(spiMasterEnable), .pwmOut0(pwmOut0), .flashOut(flashOut),
    .flashOe(flashOe), .portCIn(portCIn), .portCOut(portCOut), .portCOe(portCOe), .panelWidth(panelWidth),
    .panelData(panelData), .portDIn(portDIn), .portDOut(portDOut), .portDOe(portDOe));

  pin_world world_u (.aOut(portAOut), .aOe(portAOe), .cOut(portCOut), .cOe(portCOe), .dOut(portDOut),
    .dOe(portDOe), .extA(8'h3C), .extC(8'hE1), .extD(8'hE7), .aIn(portAIn), .cIn(portCIn), .dIn(portDIn));

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic end_sim;
    if (errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] mask);
    samples_checked++;
    if ((got & mask) !== (exp & mask)) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h mask %h", $time, got, exp, mask);
    end
  endtask

  // Ends one step after an edge so that combinational pin outputs have settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk(regReadData, exp, 8'hFF);
  endtask

  task automatic settle;
    @(posedge clk);
    #1;
  endtask

  function automatic logic [7:0] panelBits(input logic [23:0] pd);
    int lane [8] = '{0, 1, 8, 9, 16, 17, 2, 18};
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
      r[i] = pd[lane[i]];
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    end_sim();
  end

  initial begin
    {reset, regWrite, regRead, regAddr, regWriteData} = {1'b1, 1'b0, 1'b0, 8'h00, 8'h00};
    {hostMode, hostDataOut, hostDataOe, keypadScanEnable, keypadScanOut0} = {2'h1, 8'hC3, 8'h3C, 1'b0, 1'b0};
    {portBBit4Input, portBLowInputs, pwmEnable, spiMasterEnable, pwmOut0} = {1'b1, 4'hA, 1'b0, 1'b0, 1'b0};
    {flashOut, flashOe, panelWidth, panelData} = {5'h11, 5'h15, 2'h2, 24'h5A0F3C};
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd(8'hF0, 8'hFF);
    rd(8'hF3, 8'hFF);
    rd(8'hF5, 8'hFF);
    wr(8'hF7, 8'h3C);
    rd(8'hF7, 8'h00);
    // Port A is free in narrow parallel and in serial host modes; a zero direction bit drives
    for (int m = 1; m < 3; m++) begin
      @(posedge clk);
      hostMode <= 2'(m);
      wr(8'hF0, 8'h0F);
      wr(8'hF1, 8'hA5);
      chk(portAOe, 8'hF0, 8'hFF);
      chk(portAOut, 8'hA5, 8'hF0);
      repeat (4) @(posedge clk);
      rd(8'hF1, 8'hAC);
    end
    @(posedge clk);
    hostMode <= 2'h0;
    settle();
    chk(portAOe, 8'h3C, 8'hFF);
    chk(portAOut, 8'hC3, 8'hFF);
    wr(8'hF1, 8'h5A);
    chk(portAOut, 8'hC3, 8'hFF);
    @(posedge clk);
    hostMode <= 2'h1;
    settle();
    chk(portAOut, 8'h5A, 8'hF0);
    wr(8'hF2, 8'h10);
    chk({7'h00, portBBit4Output}, 8'h01, 8'h01);
    @(posedge clk);
    keypadScanEnable <= 1'b1;
    settle();
    chk({7'h00, portBBit4Output}, 8'h00, 8'h01);
    rd(8'hF2, 8'h10);
    @(posedge clk);
    hostMode <= 2'h2;
    rd(8'hF2, 8'h1A);
    wr(8'hF3, 8'h00);
    wr(8'hF4, 8'hFF);
    chk(portCOe, 8'h9F, 8'hFF);
    chk(portCOut, 8'h9F, 8'h9F);
    repeat (4) @(posedge clk);
    rd(8'hF4, 8'h9F);
    // Either owner alone takes the PWM and flash pins
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      pwmEnable <= (k == 0);
      spiMasterEnable <= (k == 1);
      settle();
      chk(portCOe, 8'h95, 8'h9F);
      chk(portCOut, 8'h11, 8'h95);
    end
    @(posedge clk);
    {pwmEnable, spiMasterEnable} <= 2'b00;
    wr(8'hF3, 8'hFF);
    chk(portCOe, 8'h00, 8'h9F);
    repeat (4) @(posedge clk);
    rd(8'hF4, 8'h81);
    wr(8'hF5, 8'h00);
    wr(8'hF6, 8'hA5);
    chk(portDOut, 8'hA5, 8'hFF);
    for (int w = 0; w < 4; w++) begin
      @(posedge clk);
      panelWidth <= 2'(w);
      settle();
      own = (w == 2) ? 8'h00 : (w == 3) ? 8'hCC : 8'hFF;
      if (w == 1) begin
        wr(8'hF6, 8'h5A);
        chk(portDOut, panelBits(panelData), 8'hFF);
      end
      chk(portDOut, (panelBits(panelData) & own) | (8'h5A & ~own), 8'hFF);
      chk(portDOe, 8'hFF, 8'hFF);
    end
    wr(8'hF5, 8'hFF);
    chk(portDOe, 8'hCC, 8'hFF);
    @(posedge clk);
    panelWidth <= 2'h2;
    settle();
    chk(portDOe, 8'h00, 8'hFF);
    repeat (4) @(posedge clk);
    rd(8'hF6, 8'hE7);
    end_sim();
  end
endmodule
